// ===== verilog/bsp_pkg.sv
// constants shared by the bus-shared port pair
package bsp_pkg;
	localparam int          BSP_AW                 = 16;
	localparam logic [15:0] BSP_DATA_DIR_ADDR      = 16'hFEBD;
	localparam logic [15:0] BSP_CTL_DIR_ADDR       = 16'hFEBE;
	localparam logic [15:0] BSP_DATA_PIN_ADDR      = 16'hFF5D;
	localparam logic [15:0] BSP_CTL_PIN_ADDR       = 16'hFF5E;
	localparam logic [15:0] BSP_DATA_LATCH_ADDR    = 16'hFF6D;
	localparam logic [15:0] BSP_CTL_LATCH_ADDR     = 16'hFF6E;
	localparam logic [15:0] BSP_PULLUP_ADDR        = 16'hFF74;
	localparam logic [15:0] BSP_STBY_CTRL_ADDR     = 16'hFF80;
	localparam logic [7:0]  BSP_ZERO_RST           = 8'h00;
	localparam logic [7:0]  BSP_CTL_DIR_RST_EXT    = 8'h80;
	localparam logic [7:0]  BSP_CTL_DIR_RST_SINGLE = 8'h00;
	localparam logic [7:0]  BSP_UNDEF_READ         = 8'hFF;
	localparam int          BSP_CLK_OUT_BIT        = 7;
	localparam int          BSP_STBY_HOLD_BIT      = 0;
	localparam logic        BSP_STBY_HOLD_RST      = 1'b1;
endpackage : bsp_pkg

// ===== verilog/bsp_pin_sync.sv
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/10ps
module bsp_pin_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);
	logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

	always_comb begin
		out_d = out_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= pin_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign pin_sync = out_q;
endmodule : bsp_pin_sync

// ===== verilog/bsp_pin_mux.sv
// combinational pin-function decode for both ports
`timescale 1ns/10ps
module bsp_pin_mux
	import bsp_pkg::*;
(
	input  wire logic       ext_bus_mode,
	input  wire logic       bus16_sel,
	input  wire logic [2:0] bus_ctl_claim,
	input  wire logic [7:0] data_dir,
	input  wire logic [7:0] pullup_en,
	input  wire logic [7:0] ctl_dir,
	output logic      [7:0] data_gpio_oe,
	output logic      [7:0] data_pullup,
	output logic            data_bus_owned,
	output logic      [7:0] ctl_gpio_oe,
	output logic      [7:0] ctl_bus_owned,
	output logic            clk_out_sel
);
	always_comb begin
		data_bus_owned = ext_bus_mode & bus16_sel;               // [RL5]
		data_gpio_oe   = data_bus_owned ? 8'h00 : data_dir;      // [RL4] [RL6]
		data_pullup    = data_bus_owned ? 8'h00 : (pullup_en & ~data_dir); // [RL1] [RL3]
		clk_out_sel    = ctl_dir[BSP_CLK_OUT_BIT];               // [RL9] [RL12]
		if (ext_bus_mode) begin
			ctl_bus_owned = {1'b0, 4'hF, bus_ctl_claim};     // [RL10] [RL11]
		end else begin
			ctl_bus_owned = 8'h00;                           // [RL12]
		end
		ctl_gpio_oe = ctl_dir & ~ctl_bus_owned & 8'h7F;          // [RL11] [RL12]
	end
endmodule : bsp_pin_mux

// ===== verilog/bsp_ports.sv
// bus-shared data-byte and bus-control i/o ports with register bank
// Summary of operation
// RL1 - pull-up on when enable set and input
// RL2 - pull-up register read/write, cleared only at power-on; the code also clears it in hardware standby
// RL3 - 16-bit external bus forces pull-ups off
// RL4 - 8-bit external bus: data pins general i/o
// RL5 - 16-bit bus: data pins owned by bus
// RL6 - single-chip modes: data pins per-bit i/o
// RL7 - control direction write-only, reads undefined
// RL8 - control direction resets 0x80 or 0x00 by mode
// RL9 - external modes: pin 7 clock or input
// RL10 - external modes: pins 6-3 always strobes
// RL11 - pins 2-0 bus-claimed or general i/o
// RL12 - single-chip modes: control pins per-bit, pin 7 clock
// RL13 - control output latch read/write, cleared at power-on
// RL14 - standby holds or floats bus control outputs
// RL15 - control pin read: latch if output, else pin
// RL16 - data pin read: latch if output, else pin
// RL17 - data direction write-only, cleared at power-on
// RL18 - mode, width, claims are static decode inputs
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
module bsp_ports
	import bsp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              hw_standby,
	input  wire logic              sw_standby,
	input  wire logic [2:0]        op_mode,
	input  wire logic              bus16_sel,
	input  wire logic [2:0]        bus_ctl_claim,
	input  wire logic [BSP_AW-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic [7:0]        data_pin_in,
	output logic      [7:0]        data_pin_out,
	output logic      [7:0]        data_pin_oe,
	output logic      [7:0]        data_pullup_on,
	input  wire logic [7:0]        bus_data_out,
	input  wire logic              bus_data_drive,
	output logic      [7:0]        bus_data_in,
	input  wire logic [7:0]        ctl_pin_in,
	output logic      [7:0]        ctl_pin_out,
	output logic      [7:0]        ctl_pin_oe,
	input  wire logic              address_strobe,
	input  wire logic              read_strobe,
	input  wire logic              high_write_strobe,
	input  wire logic              low_write_strobe,
	input  wire logic [2:0]        bus_ctl_out,
	input  wire logic [2:0]        bus_ctl_oe,
	output logic      [2:0]        bus_ctl_in,
	input  wire logic              sys_clk_level
);
	// external-bus modes 1,2,4,5,6; single-chip modes 3,7
	function automatic logic is_ext_mode(input logic [2:0] m);
		return (m == 3'h1) || (m == 3'h2) || (m == 3'h4) || (m == 3'h5) || (m == 3'h6);
	endfunction : is_ext_mode

	logic       ext_mode;
	logic [7:0] data_dir_q, data_dir_d;
	logic [7:0] data_latch_q, data_latch_d;
	logic [7:0] pullup_q, pullup_d;
	logic [7:0] ctl_dir_q, ctl_dir_d;
	logic [7:0] ctl_latch_q, ctl_latch_d;
	logic       stby_hold_q, stby_hold_d;
	logic [7:0] rdata_q, rdata_d;
	logic       init_done_q, init_done_d;
	logic [7:0] data_sync, ctl_sync;
	logic [7:0] data_gpio_oe, data_pullup, ctl_gpio_oe, ctl_bus_owned;
	logic       data_bus_owned, clk_out_sel;
	logic [7:0] ctl_drive_oe, ctl_drive_val;
	logic [7:0] ctl_hold_q, ctl_hold_d;
	logic [7:0] ctl_hold_oe_q, ctl_hold_oe_d;
	logic       sw_stby_q;

	assign ext_mode = is_ext_mode(op_mode); // [RL18]

	bsp_pin_sync #(.W(8)) u_data_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pin_in   (data_pin_in),
		.pin_sync (data_sync)
	);

	bsp_pin_sync #(.W(8)) u_ctl_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pin_in   (ctl_pin_in),
		.pin_sync (ctl_sync)
	);

	bsp_pin_mux u_mux (
		.ext_bus_mode   (ext_mode),
		.bus16_sel      (bus16_sel),
		.bus_ctl_claim  (bus_ctl_claim),
		.data_dir       (data_dir_q),
		.pullup_en      (pullup_q),
		.ctl_dir        (ctl_dir_q),
		.data_gpio_oe   (data_gpio_oe),
		.data_pullup    (data_pullup),
		.data_bus_owned (data_bus_owned),
		.ctl_gpio_oe    (ctl_gpio_oe),
		.ctl_bus_owned  (ctl_bus_owned),
		.clk_out_sel    (clk_out_sel)
	);

	// register writes; hw standby reinitialises like power-on
	always_comb begin
		data_dir_d   = data_dir_q;
		data_latch_d = data_latch_q;
		pullup_d     = pullup_q;
		ctl_dir_d    = ctl_dir_q;
		ctl_latch_d  = ctl_latch_q;
		stby_hold_d  = stby_hold_q;
		init_done_d  = 1'b1;
		if (hw_standby || !init_done_q) begin
			data_dir_d   = BSP_ZERO_RST;                                            // [RL17]
			data_latch_d = BSP_ZERO_RST;
			pullup_d     = BSP_ZERO_RST;                                            // [RL2]
			ctl_dir_d    = ext_mode ? BSP_CTL_DIR_RST_EXT : BSP_CTL_DIR_RST_SINGLE; // [RL8]
			ctl_latch_d  = BSP_ZERO_RST;                                            // [RL13]
			stby_hold_d  = BSP_STBY_HOLD_RST;
		end else if (reg_wr) begin
			if (reg_addr == BSP_DATA_DIR_ADDR) begin
				data_dir_d = reg_wdata;          // [RL17]
			end else if (reg_addr == BSP_DATA_LATCH_ADDR) begin
				data_latch_d = reg_wdata;
			end else if (reg_addr == BSP_PULLUP_ADDR) begin
				pullup_d = reg_wdata;            // [RL2]
			end else if (reg_addr == BSP_CTL_DIR_ADDR) begin
				ctl_dir_d = reg_wdata;           // [RL7]
			end else if (reg_addr == BSP_CTL_LATCH_ADDR) begin
				ctl_latch_d = reg_wdata;         // [RL13]
			end else if (reg_addr == BSP_STBY_CTRL_ADDR) begin
				stby_hold_d = reg_wdata[BSP_STBY_HOLD_BIT];
			end
		end
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			if (reg_addr == BSP_DATA_DIR_ADDR || reg_addr == BSP_CTL_DIR_ADDR) begin
				rdata_d = BSP_UNDEF_READ;                                                // [RL7] [RL17]
			end else if (reg_addr == BSP_DATA_PIN_ADDR) begin
				rdata_d = (data_dir_q & data_latch_q) | (~data_dir_q & data_sync);     // [RL16]
			end else if (reg_addr == BSP_CTL_PIN_ADDR) begin
				rdata_d = (ctl_dir_q & ctl_latch_q) | (~ctl_dir_q & ctl_sync);         // [RL15]
			end else if (reg_addr == BSP_DATA_LATCH_ADDR) begin
				rdata_d = data_latch_q;
			end else if (reg_addr == BSP_CTL_LATCH_ADDR) begin
				rdata_d = ctl_latch_q;                                                 // [RL13]
			end else if (reg_addr == BSP_PULLUP_ADDR) begin
				rdata_d = pullup_q;                                                    // [RL2]
			end else if (reg_addr == BSP_STBY_CTRL_ADDR) begin
				rdata_d = {7'h00, stby_hold_q};
			end
		end
	end

	// live control-port drive before the standby override
	always_comb begin
		ctl_drive_oe  = ctl_gpio_oe | ctl_bus_owned;
		ctl_drive_val = ctl_latch_q;
		if (ext_mode) begin
			ctl_drive_oe[2:0] = (ctl_gpio_oe[2:0] & ~bus_ctl_claim) | (bus_ctl_oe & bus_ctl_claim); // [RL11]
			ctl_drive_val[6:0] = {address_strobe, read_strobe, high_write_strobe, low_write_strobe,
				(bus_ctl_claim & bus_ctl_out) | (~bus_ctl_claim & ctl_latch_q[2:0])};       // [RL10] [RL11]
		end
		ctl_drive_oe[BSP_CLK_OUT_BIT]  = clk_out_sel;   // [RL9] [RL12]
		ctl_drive_val[BSP_CLK_OUT_BIT] = sys_clk_level;
		// snapshot tracks live drive until standby freezes it
		ctl_hold_d    = sw_stby_q ? ctl_hold_q : ctl_drive_val;
		ctl_hold_oe_d = sw_stby_q ? ctl_hold_oe_q : ctl_drive_oe;
	end

	// power-on reset is the only asynchronous clear; manual reset never reaches here
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_dir_q    <= BSP_ZERO_RST;
			data_latch_q  <= BSP_ZERO_RST;
			pullup_q      <= BSP_ZERO_RST;
			ctl_dir_q     <= BSP_ZERO_RST;
			ctl_latch_q   <= BSP_ZERO_RST;
			stby_hold_q   <= BSP_STBY_HOLD_RST;
			rdata_q       <= 8'h00;
			init_done_q   <= 1'b0;
			ctl_hold_q    <= 8'h00;
			ctl_hold_oe_q <= 8'h00;
			sw_stby_q     <= 1'b0;
		end else begin
			data_dir_q    <= data_dir_d;
			data_latch_q  <= data_latch_d;
			pullup_q      <= pullup_d;
			ctl_dir_q     <= ctl_dir_d;
			ctl_latch_q   <= ctl_latch_d;
			stby_hold_q   <= stby_hold_d;
			rdata_q       <= rdata_d;
			init_done_q   <= init_done_d;
			ctl_hold_q    <= ctl_hold_d;
			ctl_hold_oe_q <= ctl_hold_oe_d;
			sw_stby_q     <= sw_standby;
		end
	end

	assign reg_rdata = rdata_q;

	// data-byte port: gpio or external bus upper byte
	// hardware standby floats the pins at once, before the registers reinitialise
	assign data_pin_oe    = hw_standby ? 8'h00 : (data_bus_owned ? {8{bus_data_drive}} : data_gpio_oe); // [RL4] [RL5] [RL6]
	assign data_pin_out   = data_bus_owned ? bus_data_out : data_latch_q;        // [RL5]
	assign data_pullup_on = hw_standby ? 8'h00 : data_pullup;                    // [RL1] [RL3]
	assign bus_data_in    = data_sync;
	assign bus_ctl_in     = ctl_sync[2:0];

	// standby: bus-control pins hold snapshot or float; gpio pins keep latch
	always_comb begin
		ctl_pin_out = ctl_drive_val;
		ctl_pin_oe  = ctl_drive_oe;
		if (sw_stby_q && ext_mode) begin
			ctl_pin_out[6:3] = ctl_hold_q[6:3];                                   // [RL14]
			ctl_pin_oe[6:3]  = stby_hold_q ? ctl_hold_oe_q[6:3] : 4'h0;           // [RL14]
			ctl_pin_out[2:0] = (bus_ctl_claim & ctl_hold_q[2:0]) | (~bus_ctl_claim & ctl_drive_val[2:0]);
			ctl_pin_oe[2:0]  = (bus_ctl_claim & (stby_hold_q ? ctl_hold_oe_q[2:0] : 3'h0))
				| (~bus_ctl_claim & ctl_drive_oe[2:0]);                               // [RL14]
		end
		if (hw_standby) begin
			ctl_pin_oe = 8'h00;
		end
	end
endmodule : bsp_ports

// ===== bench/bsp_pins.sv
// pin-side model: external devices and pull-ups on one port
`timescale 1ns/10ps
module bsp_pins (
	input  wire logic [7:0] ext_level,
	input  wire logic [7:0] ext_drive,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pull_en,
	output logic      [7:0] pin_in
);
	// a floating pin without pull-up reads the inverse, never a lucky match
	always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level)
		| (~pin_oe & ~ext_drive & (pull_en | ~ext_level));
endmodule : bsp_pins

// ===== bench/bsp_ports_sva.sv
// concurrent checks on the bus-shared port pair
`timescale 1ns/10ps
module bsp_ports_sva
	import bsp_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              hw_standby,
	input wire logic              sw_standby,
	input wire logic [2:0]        op_mode,
	input wire logic              bus16_sel,
	input wire logic [2:0]        bus_ctl_claim,
	input wire logic [BSP_AW-1:0] reg_addr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	input wire logic [7:0]        data_pin_oe,
	input wire logic [7:0]        data_pullup_on,
	input wire logic              bus_data_drive,
	input wire logic [7:0]        ctl_pin_out,
	input wire logic [7:0]        ctl_pin_oe,
	input wire logic [2:0]        bus_ctl_oe,
	input wire logic              sys_clk_level
);
	wire logic ext = !(op_mode == 3'h3 || op_mode == 3'h7);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_PULLUP_INPUT: assert property ((data_pullup_on & data_pin_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	AST_WIDE_PULLUP: assert property (ext && bus16_sel |-> data_pullup_on == 8'h00)
		else $error("pull-up on in wide bus mode");
	AST_WIDE_DATA: assert property (ext && bus16_sel && !hw_standby && !sw_standby && !$past(sw_standby)
		|-> data_pin_oe == {8{bus_data_drive}}) else $error("data pins not owned by bus");
	AST_STROBE_PINS: assert property (ext && !hw_standby && !sw_standby && !$past(sw_standby)
		|-> ctl_pin_oe[6:3] == 4'hF) else $error("strobe pins not driven");
	AST_CLAIM_PINS: assert property (ext && !hw_standby && !sw_standby && !$past(sw_standby)
		|-> ((ctl_pin_oe[2:0] ^ bus_ctl_oe) & bus_ctl_claim) == 3'h0) else $error("claimed pin mismatch");
	AST_CLOCK_OUT: assert property (!hw_standby && !sw_standby && ctl_pin_oe[7]
		|-> ctl_pin_out[7] == sys_clk_level) else $error("clock output wrong");
	AST_CTL_DIR_READ: assert property ($past(reg_rd) && $past(reg_addr) == BSP_CTL_DIR_ADDR
		|-> reg_rdata == BSP_UNDEF_READ) else $error("control direction readable");
	AST_DATA_DIR_READ: assert property ($past(reg_rd) && $past(reg_addr) == BSP_DATA_DIR_ADDR
		|-> reg_rdata == BSP_UNDEF_READ) else $error("data direction readable");
	AST_HW_STANDBY: assert property (hw_standby |-> (data_pin_oe | ctl_pin_oe | data_pullup_on) == 8'h00)
		else $error("pins active in hardware standby");
	cover property (ext && bus16_sel && bus_data_drive);
	cover property ($past(reg_rd) && reg_rdata != 8'h00);
	cover property (data_pullup_on != 8'h00);
endmodule : bsp_ports_sva
bind bsp_ports bsp_ports_sva u_sva (.*);

// ===== bench/tb_bsp_ports.sv
// self-checking bench for the bus-shared port pair
`timescale 1ns/10ps
module tb_bsp_ports;
	import bsp_pkg::*;
	logic clk = 0, reset_n = 0, hw_standby = 0, sw_standby = 0, bus16_sel = 0, reg_wr = 0, reg_rd = 0;
	logic bus_data_drive = 0, sys_clk_level = 0;
	logic [2:0] op_mode = 3'h5, bus_ctl_claim = 3'h0, bus_ctl_oe = 3'h0, bus_ctl_out = 3'h0, bus_ctl_in;
	logic [3:0] stb = 4'hA;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00, bus_data_out = 8'h00, d_ext = 8'h3C, c_ext = 8'hFF;
	logic [7:0] reg_rdata, data_pin_in, data_pin_out, data_pin_oe, data_pullup_on, bus_data_in;
	logic [7:0] ctl_pin_in, ctl_pin_out, ctl_pin_oe;
	int err_count = 0, comparisons = 0;
	always #4 clk = ~clk;
	always @(posedge clk) sys_clk_level <= ~sys_clk_level;
	bsp_ports u_dut (.clk, .reset_n, .hw_standby, .sw_standby, .op_mode, .bus16_sel, .bus_ctl_claim,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .data_pin_in, .data_pin_out, .data_pin_oe,
		.data_pullup_on, .bus_data_out, .bus_data_drive, .bus_data_in, .ctl_pin_in, .ctl_pin_out,
		.ctl_pin_oe, .address_strobe(stb[3]), .read_strobe(stb[2]), .high_write_strobe(stb[1]),
		.low_write_strobe(stb[0]), .bus_ctl_out, .bus_ctl_oe, .bus_ctl_in, .sys_clk_level);
	// data pins float so pull-ups decide undriven levels
	bsp_pins u_dpins (.ext_level(d_ext), .ext_drive(8'h00), .pin_out(data_pin_out), .pin_oe(data_pin_oe),
		.pull_en(data_pullup_on), .pin_in(data_pin_in));
	bsp_pins u_cpins (.ext_level(c_ext), .ext_drive(8'hFF), .pin_out(ctl_pin_out), .pin_oe(ctl_pin_oe),
		.pull_en(8'h00), .pin_in(ctl_pin_in));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, "reg_rdata");
		@(posedge clk);
	endtask : rd
	// mode and width only change while reset is held
	task automatic rst(input logic [2:0] m, input logic b16);
		reset_n <= 1'b0;
		op_mode <= m;
		bus16_sel <= b16;
		cyc(6);
		reset_n <= 1'b1;
		cyc(2);
	endtask : rst
	task automatic t_reset();
		rst(3'h5, 1'b0);
		chk(ctl_pin_oe & 8'h80, 8'h80, "ctl_pin_oe");
		rd(BSP_PULLUP_ADDR, 8'h00);
		rd(BSP_CTL_LATCH_ADDR, 8'h00);
		rd(BSP_CTL_DIR_ADDR, BSP_UNDEF_READ);
		rd(BSP_DATA_DIR_ADDR, BSP_UNDEF_READ);
		rd(16'h0000, 8'h00);
		wr(BSP_CTL_LATCH_ADDR, 8'h5A);
		rd(BSP_CTL_LATCH_ADDR, 8'h5A);
		$display("reset test done");
	endtask : t_reset
	task automatic t_single();
		rst(3'h3, 1'b0);
		chk(ctl_pin_oe, 8'h00, "ctl_pin_oe");
		wr(BSP_DATA_DIR_ADDR, 8'h0F);
		wr(BSP_DATA_LATCH_ADDR, 8'hA5);
		wr(BSP_PULLUP_ADDR, 8'hFF);
		wr(BSP_CTL_DIR_ADDR, 8'h41);
		wr(BSP_CTL_LATCH_ADDR, 8'h00);
		cyc(5);
		#1 chk(data_pin_oe, 8'h0F, "data_pin_oe");
		chk(data_pin_out & 8'h0F, 8'h05, "data_pin_out");
		chk(data_pullup_on, 8'hF0, "data_pullup_on");
		chk(ctl_pin_oe, 8'h41, "ctl_pin_oe");
		cyc(1);
		rd(BSP_DATA_PIN_ADDR, 8'hF5);
		rd(BSP_CTL_PIN_ADDR, 8'hBE);
		$display("single-chip test done");
	endtask : t_single
	task automatic t_ext8();
		bus_ctl_claim <= 3'h5;
		bus_ctl_oe <= 3'h7;
		rst(3'h5, 1'b0);
		wr(BSP_DATA_DIR_ADDR, 8'hF0);
		wr(BSP_PULLUP_ADDR, 8'hFF);
		wr(BSP_CTL_DIR_ADDR, 8'h02);
		#1 chk(data_pin_oe, 8'hF0, "data_pin_oe");
		chk(data_pullup_on, 8'h0F, "data_pullup_on");
		chk(ctl_pin_oe, 8'h7F, "ctl_pin_oe");
		chk(ctl_pin_out & 8'h78, 8'h50, "ctl_pin_out");
		@(posedge clk);
		bus_ctl_oe <= 3'h0;
		#1 chk(ctl_pin_oe, 8'h7A, "ctl_pin_oe");
		cyc(5);
		#1 chk({5'h00, bus_ctl_in}, 8'h05, "bus_ctl_in");
		@(posedge clk);
		$display("narrow bus test done");
	endtask : t_ext8
	task automatic t_ext16();
		rst(3'h5, 1'b1);
		wr(BSP_PULLUP_ADDR, 8'hFF);
		bus_data_drive <= 1'b1;
		bus_data_out <= 8'h96;
		#1 chk(data_pullup_on, 8'h00, "data_pullup_on");
		chk(data_pin_oe, 8'hFF, "data_pin_oe");
		chk(data_pin_out, 8'h96, "data_pin_out");
		@(posedge clk);
		bus_data_drive <= 1'b0;
		cyc(5);
		#1 chk(bus_data_in, 8'hC3, "bus_data_in");
		@(posedge clk);
		$display("wide bus test done");
	endtask : t_ext16
	task automatic t_standby();
		wr(BSP_PULLUP_ADDR, 8'h55);
		sw_standby <= 1'b1;
		cyc(4);
		#1 chk(ctl_pin_oe & 8'h78, 8'h78, "ctl_pin_oe");
		@(posedge clk);
		sw_standby <= 1'b0;
		cyc(2);
		rd(BSP_PULLUP_ADDR, 8'h55);
		wr(BSP_STBY_CTRL_ADDR, 8'h00);
		sw_standby <= 1'b1;
		cyc(4);
		#1 chk(ctl_pin_oe & 8'h78, 8'h00, "ctl_pin_oe");
		@(posedge clk);
		sw_standby <= 1'b0;
		hw_standby <= 1'b1;
		cyc(2);
		hw_standby <= 1'b0;
		cyc(2);
		rd(BSP_PULLUP_ADDR, 8'h00);
		chk(ctl_pin_oe & 8'h80, 8'h80, "ctl_pin_oe");
		$display("standby test done");
	endtask : t_standby
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	initial begin
		#200000;
		err_count++;
		finish_test();
	end
	initial begin
		t_reset();
		t_single();
		t_ext8();
		t_ext16();
		t_standby();
		finish_test();
	end
endmodule : tb_bsp_ports
